/* rtl/siopf_params.svh */
// Register offsets, field positions, reset values and timing for the status pin block
`ifndef SIOPF_PARAMS_SVH
`define SIOPF_PARAMS_SVH
`define SIOPF_CTRL_OFS 12'h000
`define SIOPF_PWM2_PER_OFS 12'h004
`define SIOPF_PWM2_LOW_OFS 12'h008
`define SIOPF_PWM3_PER_OFS 12'h00c
`define SIOPF_PWM3_LOW_OFS 12'h010
`define SIOPF_STAT_OFS 12'h014
`define SIOPF_CTRL_FN2_LSB 0
`define SIOPF_CTRL_INV2_BIT 2
`define SIOPF_CTRL_VAL2_LSB 3
`define SIOPF_CTRL_FN3_LSB 8
`define SIOPF_CTRL_INV3_BIT 10
`define SIOPF_CTRL_VAL3_LSB 11
`define SIOPF_STAT_IN2_BIT 0
`define SIOPF_STAT_IN3_BIT 1
`define SIOPF_STAT_PROT_BIT 2
`define SIOPF_STAT_OFF_BIT 3
`define SIOPF_STAT_PIN2_BIT 4
`define SIOPF_STAT_PIN3_BIT 5
`define SIOPF_CTRL_RST 32'h0000_0000
`define SIOPF_CLK_HZ 100000000
`define SIOPF_PWM_HZ 100
`define SIOPF_PWM_PER_CYC (`SIOPF_CLK_HZ / `SIOPF_PWM_HZ)
`define SIOPF_PWM_LOW_CYC (`SIOPF_PWM_PER_CYC / 10)
`endif

/* rtl/siopf_pkg.sv */
// Types for the status pin block
package siopf_pkg;
  typedef enum logic [1:0] {
    SIOPF_FN_STATUS = 2'h0,
    SIOPF_FN_INPUT = 2'h1,
    SIOPF_FN_OUTPUT = 2'h2
  } siopf_fn_e;
  typedef enum logic [1:0] {
    SIOPF_VAL_FALSE = 2'h0,
    SIOPF_VAL_TRUE = 2'h1,
    SIOPF_VAL_PWM = 2'h2
  } siopf_val_e;
endpackage

/* rtl/siopf_status_io.sv */
// Status pins two and three with AHB-Lite register access
// How it works
// RULE1: Pin two selects protection status, general input or general output.
// RULE2: Pin three selects output-off status, general input or general output.
// RULE3: Each pin has an invert bit reversing input and output sense.
// RULE4: Protection status, normal polarity: pin high while not protected.
// RULE5: Protection status, normal polarity: pin low while any protection active.
// RULE6: Inverted polarity gives exactly opposite protection status levels.
// RULE7: Output-off status, normal polarity: pin high while output switched off.
// RULE8: Output-off status, normal polarity: pin low while output switched on.
// RULE9: Inverted polarity gives opposite output-off status levels.
// RULE10: General output true is logical one: low normal, high inverted.
// RULE11: General output false is logical zero: high normal, low inverted.
// RULE12: General input syncs the pin level and reports it with polarity applied.
// RULE13: General output offers PWM with programmable period and low time.
// RULE14: Duty sets the low (active) part; 100Hz 10% gives 1ms low.
// RULE15: External party drives defined levels on a pin used as input.
// RULE16: Outputs registered; inputs pass two flip-flops before use.
`timescale 1ns/1ps
`default_nettype none
`include "siopf_params.svh"
module siopf_status_io
  import siopf_pkg::*;
#(
  parameter int PWM_W = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic protection_state_out,
  input wire logic output_switch_on,
  input wire logic pin2_i,
  output logic pin2_o,
  output logic pin2_oe_n,
  input wire logic pin3_i,
  output logic pin3_o,
  output logic pin3_oe_n
);
  // Register map, byte offsets, one word each:
  // CTRL fn2[1:0] inv2[2] val2[4:3] fn3[9:8] inv3[10] val3[12:11]
  // PWM2 period, PWM2 low time, then the same pair for pin three
  // STATUS in2, in3, protected, output off, pin2 drive, pin3 drive
  // Function code 3 acts as general output, value code 3 as False

  // Counter widths the logic cannot serve, or a reset period cut short
  if (PWM_W < 8 || PWM_W > 32) begin : g_bad_width
    $error("PWM_W out of range");
  end
  if (PWM_W < 32 && (64'(`SIOPF_PWM_PER_CYC) >> PWM_W) != 64'h0) begin : g_bad_reset
    $error("PWM_W too narrow for the reset period");
  end

  localparam logic [31:0] PER_RST = 32'(`SIOPF_PWM_PER_CYC);
  localparam logic [31:0] LOW_RST = 32'(`SIOPF_PWM_LOW_CYC);

  // AHB-Lite address phase capture; hsize is not decoded, every access is a word
  logic wr_pend_q;
  logic rd_pend_q;
  logic [11:0] addr_q;
  logic [31:0] ctrl_q;
  logic [PWM_W-1:0] per2_q;
  logic [PWM_W-1:0] low2_q;
  logic [PWM_W-1:0] per3_q;
  logic [PWM_W-1:0] low3_q;
  logic [31:0] rdata_d;
  logic addr_ok;
  logic [5:0] stat_w;

  wire logic take = hsel && hready && htrans[1];

  // Data phase follows the taken address phase by one edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_q <= 12'h000;
    end else if (take) begin
      addr_q <= haddr;
    end
  end

  // One write strobe per writable register, valid while hwdata stands
  wire logic wr_ctrl = wr_pend_q && (addr_q == `SIOPF_CTRL_OFS);
  wire logic wr_per2 = wr_pend_q && (addr_q == `SIOPF_PWM2_PER_OFS);
  wire logic wr_low2 = wr_pend_q && (addr_q == `SIOPF_PWM2_LOW_OFS);
  wire logic wr_per3 = wr_pend_q && (addr_q == `SIOPF_PWM3_PER_OFS);
  wire logic wr_low3 = wr_pend_q && (addr_q == `SIOPF_PWM3_LOW_OFS);

  // Bits outside the fields are dropped so they read back as zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `SIOPF_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata & 32'h0000_1f1f;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per2_q <= PER_RST[PWM_W-1:0];
    end else if (wr_per2) begin
      per2_q <= hwdata[PWM_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low2_q <= LOW_RST[PWM_W-1:0];
    end else if (wr_low2) begin
      low2_q <= hwdata[PWM_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per3_q <= PER_RST[PWM_W-1:0];
    end else if (wr_per3) begin
      per3_q <= hwdata[PWM_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low3_q <= LOW_RST[PWM_W-1:0];
    end else if (wr_low3) begin
      low3_q <= hwdata[PWM_W-1:0];
    end
  end

  // Field decode
  wire siopf_fn_e fn2 = siopf_fn_e'(ctrl_q[`SIOPF_CTRL_FN2_LSB +: 2]);
  wire siopf_fn_e fn3 = siopf_fn_e'(ctrl_q[`SIOPF_CTRL_FN3_LSB +: 2]);
  wire siopf_val_e val2 = siopf_val_e'(ctrl_q[`SIOPF_CTRL_VAL2_LSB +: 2]);
  wire siopf_val_e val3 = siopf_val_e'(ctrl_q[`SIOPF_CTRL_VAL3_LSB +: 2]);
  wire logic inv2 = ctrl_q[`SIOPF_CTRL_INV2_BIT]; // RULE3
  wire logic inv3 = ctrl_q[`SIOPF_CTRL_INV3_BIT]; // RULE3

  // Two-stage synchronisers; only the second stage is read
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] inst_s1_q;
  logic [1:0] inst_s2_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
    end else begin
      pin_s1_q <= {pin3_i, pin2_i}; // RULE16
      pin_s2_q <= pin_s1_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inst_s1_q <= 2'h0;
      inst_s2_q <= 2'h0;
    end else begin
      inst_s1_q <= {output_switch_on, protection_state_out}; // RULE16
      inst_s2_q <= inst_s1_q;
    end
  end
  wire logic prot_s = inst_s2_q[0];
  wire logic on_s = inst_s2_q[1];
  wire logic in2_lvl = pin_s2_q[0] ^ inv2; // RULE12
  wire logic in3_lvl = pin_s2_q[1] ^ inv3; // RULE12

  // PWM counters run only while PWM is chosen; each period opens with the low part
  logic [PWM_W-1:0] cnt2_q;
  logic [PWM_W-1:0] cnt3_q;
  logic [PWM_W-1:0] per2_a_q;
  logic [PWM_W-1:0] low2_a_q;
  logic [PWM_W-1:0] per3_a_q;
  logic [PWM_W-1:0] low3_a_q;
  wire logic [PWM_W-1:0] nxt2 = cnt2_q + 1'b1;
  wire logic [PWM_W-1:0] nxt3 = cnt3_q + 1'b1;
  wire logic wrap2 = nxt2 >= per2_a_q;
  wire logic wrap3 = nxt3 >= per3_a_q;

  // While PWM runs, settings are taken over only at a wrap, so a write never leaves a runt period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per2_a_q <= PER_RST[PWM_W-1:0];
      low2_a_q <= LOW_RST[PWM_W-1:0];
    end else if (val2 != SIOPF_VAL_PWM || wrap2) begin
      per2_a_q <= per2_q;
      low2_a_q <= low2_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per3_a_q <= PER_RST[PWM_W-1:0];
      low3_a_q <= LOW_RST[PWM_W-1:0];
    end else if (val3 != SIOPF_VAL_PWM || wrap3) begin
      per3_a_q <= per3_q;
      low3_a_q <= low3_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt2_q <= '0;
    end else if (val2 != SIOPF_VAL_PWM) begin
      cnt2_q <= '0;
    end else if (wrap2) begin
      cnt2_q <= '0; // RULE13
    end else begin
      cnt2_q <= nxt2; // RULE13
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt3_q <= '0;
    end else if (val3 != SIOPF_VAL_PWM) begin
      cnt3_q <= '0;
    end else if (wrap3) begin
      cnt3_q <= '0; // RULE13
    end else begin
      cnt3_q <= nxt3; // RULE13
    end
  end
  // Logical one while in the low (active) part
  wire logic pwm2_one = cnt2_q < low2_a_q; // RULE14
  wire logic pwm3_one = cnt3_q < low3_a_q; // RULE14

  // Pin level before polarity: a logical one drives low
  logic lvl2_d;
  logic lvl3_d;
  always_comb begin
    lvl2_d = 1'b1;
    if (fn2 == SIOPF_FN_STATUS) begin
      lvl2_d = !prot_s; // RULE4 RULE5
    end else begin
      case (val2)
        SIOPF_VAL_TRUE: lvl2_d = 1'b0; // RULE10
        SIOPF_VAL_PWM: lvl2_d = !pwm2_one; // RULE13
        default: lvl2_d = 1'b1; // RULE11
      endcase
    end
  end

  always_comb begin
    lvl3_d = 1'b1;
    if (fn3 == SIOPF_FN_STATUS) begin
      lvl3_d = !on_s; // RULE7 RULE8
    end else begin
      case (val3)
        SIOPF_VAL_TRUE: lvl3_d = 1'b0; // RULE10
        SIOPF_VAL_PWM: lvl3_d = !pwm3_one; // RULE13
        default: lvl3_d = 1'b1; // RULE11
      endcase
    end
  end

  // Registered pins; input function releases the pin but keeps a level on pin*_o
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin2_o <= 1'b1;
      pin2_oe_n <= 1'b1;
    end else begin
      pin2_o <= lvl2_d ^ inv2; // RULE6 RULE10 RULE11 RULE16
      pin2_oe_n <= (fn2 == SIOPF_FN_INPUT); // RULE1
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin3_o <= 1'b1;
      pin3_oe_n <= 1'b1;
    end else begin
      pin3_o <= lvl3_d ^ inv3; // RULE9 RULE10 RULE11 RULE16
      pin3_oe_n <= (fn3 == SIOPF_FN_INPUT); // RULE2
    end
  end

  // Read path
  always_comb begin
    stat_w = 6'h00;
    stat_w[`SIOPF_STAT_IN2_BIT] = in2_lvl; // RULE12
    stat_w[`SIOPF_STAT_IN3_BIT] = in3_lvl; // RULE12
    stat_w[`SIOPF_STAT_PROT_BIT] = prot_s;
    stat_w[`SIOPF_STAT_OFF_BIT] = !on_s;
    stat_w[`SIOPF_STAT_PIN2_BIT] = pin2_o;
    stat_w[`SIOPF_STAT_PIN3_BIT] = pin3_o;
  end

  always_comb begin
    addr_ok = 1'b1;
    rdata_d = 32'h0000_0000;
    case (addr_q)
      `SIOPF_CTRL_OFS: rdata_d = ctrl_q;
      `SIOPF_PWM2_PER_OFS: rdata_d = 32'(per2_q);
      `SIOPF_PWM2_LOW_OFS: rdata_d = 32'(low2_q);
      `SIOPF_PWM3_PER_OFS: rdata_d = 32'(per3_q);
      `SIOPF_PWM3_LOW_OFS: rdata_d = 32'(low3_q);
      `SIOPF_STAT_OFS: rdata_d = {26'h0, stat_w};
      default: addr_ok = 1'b0;
    endcase
  end

  // Every transfer, mapped or not, is answered OKAY
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Read data registered during the data phase costs one wait state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
    end else if (take && !hwrite) begin
      hreadyout <= 1'b0;
    end else if (rd_pend_q) begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata <= addr_ok ? rdata_d : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* verif/siopf_status_io_asserts.sv */
// Port checks for the status pin block
`timescale 1ns/1ps
`default_nettype none
`include "siopf_params.svh"
module siopf_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic protection_state_out,
  input wire logic output_switch_on,
  input wire logic pin2_o,
  input wire logic pin2_oe_n,
  input wire logic pin3_o,
  input wire logic pin3_oe_n
);
  logic wr_q;
  logic [12:0] c_q;
  // Shadow of the control word, taken in the write data phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b0;
      c_q <= 13'h0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr == `SIOPF_CTRL_OFS;
      if (wr_q) c_q <= hwdata[12:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_take(w); hsel && hready && htrans[1] && hwrite == w; endsequence
  // Five quiet cycles cover sync plus output register
  sequence s_calm(x); ($stable(c_q) && $stable(x)) [*5]; endsequence
  property p_rd; s_take(1'b0) |=> !hreadyout ##1 hreadyout; endproperty
  property p_wr; s_take(1'b1) |=> hreadyout; endproperty
  property p_okay; !hresp; endproperty
  property p_prot2; s_calm(protection_state_out) ##0 c_q[1:0] == 2'h0 |-> pin2_o == (!protection_state_out ^ c_q[2]);
  endproperty
  property p_off3; s_calm(output_switch_on) ##0 c_q[9:8] == 2'h0 |-> pin3_o == (!output_switch_on ^ c_q[10]);
  endproperty
  property p_out2; s_calm(1'b0) ##0 c_q[1:0] == 2'h2 && c_q[4:3] != 2'h2 |-> pin2_o == ((c_q[4:3] != 2'h1) ^ c_q[2]);
  endproperty
  property p_out3; s_calm(1'b0) ##0 c_q[9:8] == 2'h2 && c_q[12:11] != 2'h2 |-> pin3_o == ((c_q[12:11] != 2'h1) ^ c_q[10]);
  endproperty
  property p_oe; s_calm(1'b0) |-> pin2_oe_n == (c_q[1:0] == 2'h1) && pin3_oe_n == (c_q[9:8] == 2'h1); endproperty
  a_rd: assert property (p_rd) else $error("read wait state wrong");
  a_wr: assert property (p_wr) else $error("write stalled");
  a_okay: assert property (p_okay) else $error("error response");
  a_prot2: assert property (p_prot2) else $error("pin two status level wrong");
  a_off3: assert property (p_off3) else $error("pin three status level wrong");
  a_out2: assert property (p_out2) else $error("pin two fixed output wrong");
  a_out3: assert property (p_out3) else $error("pin three fixed output wrong");
  a_oe: assert property (p_oe) else $error("pin direction wrong");
endmodule
bind siopf_status_io siopf_asserts siopf_asserts_inst (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .protection_state_out, .output_switch_on, .pin2_o, .pin2_oe_n, .pin3_o, .pin3_oe_n);
`default_nettype wire

/* verif/siopf_ext_model.sv */
// External equipment on one status pin
`timescale 1ns/1ps
`default_nettype none
module siopf_ext_model (
  input wire logic drv_oe_n,
  input wire logic drv_o,
  input wire logic ext_lvl,
  output logic pin_lvl
);
  // Equipment drives a defined level whenever the block lets go
  assign pin_lvl = !drv_oe_n ? drv_o : ext_lvl;
endmodule
`default_nettype wire

/* verif/status_io_pin_function_bench.sv */
// Self-checking bench for the status pin block
`timescale 1ns/1ps
`default_nettype none
`include "siopf_params.svh"
module status_io_pin_function_bench;
  logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, prot = 0, on = 0, l2 = 0, l3 = 0, win = 0, win_q = 0, ph = 0;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, cnt = 0, cnt3 = 0, c;
  logic [63:0] q[$], nt;
  logic hreadyout, hresp, p2, p3, o2, o3, n2, n3, a, b;
  int checks = 0, n_fail = 0;
  siopf_status_io siopf_status_io_inst (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .protection_state_out(prot), .output_switch_on(on),
    .pin2_i(p2), .pin2_o(o2), .pin2_oe_n(n2), .pin3_i(p3), .pin3_o(o3), .pin3_oe_n(n3));
  siopf_ext_model ext2 (.drv_oe_n(n2), .drv_o(o2), .ext_lvl(l2), .pin_lvl(p2));
  siopf_ext_model ext3 (.drv_oe_n(n3), .drv_o(o3), .ext_lvl(l3), .pin_lvl(p3));
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Read notes {mask, expected}; the monitor compares
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [31:0] m);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= ad;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) q.push_back({m, d});
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask
  always @(posedge sys_clk) begin
    if (ph && hreadyout) begin
      nt = q.pop_front();
      chk(hrdata & nt[63:32], nt[31:0]);
      ph = 0;
    end
    if (hsel && hreadyout && htrans[1] && !hwrite) ph = 1;
    if (win) cnt = cnt + {31'h0, !o2};
    if (win) cnt3 = cnt3 + {31'h0, !o3};
    if (win_q && !win) begin
      nt = q.pop_front();
      chk(cnt, nt[31:0]);
      nt = q.pop_front();
      chk(cnt3, nt[31:0]);
      cnt = 0;
      cnt3 = 0;
    end
    win_q = win;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    end_of_test;
  end
  initial begin
    void'($urandom(13504));
    repeat (6) @(posedge sys_clk);
    rst <= 0;
    bus(0, `SIOPF_PWM2_PER_OFS, 32'd1000000, 32'hffff_ffff);
    bus(0, `SIOPF_PWM3_LOW_OFS, 32'd100000, 32'hffff_ffff);
    bus(0, 12'h018, 32'h0, 32'hffff_ffff);
    // Every status input, polarity and fixed value on both pins
    for (int i = 0; i < 64; i++) begin
      c = {19'h0, 1'b0, i[4], i[3], i[5], 1'b0, 3'h0, 1'b0, i[4], i[2], i[5], 1'b0};
      prot <= i[0];
      on <= i[1];
      bus(1, `SIOPF_CTRL_OFS, c, 32'h0);
      repeat (8) @(posedge sys_clk);
      a = (i[5] ? !i[4] : !i[0]) ^ i[2];
      b = (i[5] ? !i[4] : !i[1]) ^ i[3];
      bus(0, `SIOPF_STAT_OFS, {26'h0, b, a, !i[1], i[0], b ^ i[3], a ^ i[2]}, 32'hffff_ffff);
    end
    for (int i = 0; i < 8; i++) begin
      c = $urandom;
      l2 <= c[0];
      l3 <= c[1];
      bus(1, `SIOPF_CTRL_OFS, {21'h0, c[3], 2'h1, 5'h0, c[2], 2'h1}, 32'h0);
      repeat (6) @(posedge sys_clk);
      bus(0, `SIOPF_STAT_OFS, {30'h0, c[1] ^ c[3], c[0] ^ c[2]}, 32'h3);
    end
    // Short periods keep the run brief; 90 cycles hold whole periods on both pins
    bus(1, `SIOPF_PWM2_PER_OFS, 32'd9, 32'h0);
    bus(1, `SIOPF_PWM2_LOW_OFS, 32'd4, 32'h0);
    bus(1, `SIOPF_PWM3_PER_OFS, 32'd6, 32'h0);
    bus(1, `SIOPF_PWM3_LOW_OFS, 32'd1, 32'h0);
    for (int k = 0; k < 2; k++) begin
      bus(1, `SIOPF_CTRL_OFS, k ? 32'h1616 : 32'h1212, 32'h0);
      repeat (20) @(posedge sys_clk);
      q.push_back({32'hffff_ffff, k ? 32'd50 : 32'd40});
      q.push_back({32'hffff_ffff, k ? 32'd75 : 32'd15});
      win <= 1;
      repeat (90) @(posedge sys_clk);
      win <= 0;
      repeat (2) @(posedge sys_clk);
    end
    end_of_test;
  end
endmodule
`default_nettype wire
